// ===== rtl/grouped_status_bus_reporter.sv
`timescale 1ns/1ps
// Summary of operation
// - Control A bit 0 enables group participation; register resets to zero.
// - Control A bits 1-3 choose which bus line this device drives.
// - Control B bits 0-2 pick third register status, T1 code mapping.
// - E1 mode uses its own mapping; codes 110 and 111 give zero.
// - Control B bits 4-6 pick fourth register status, same mapping.
// - First info read drives interrupt pending status on selected line.
// - Second info read drives loss-of-sync status on selected line.
// - Third info read drives status chosen by third select field.
// - Fourth info read drives status chosen by fourth select field.
// - At most eight members share the 8-bit bus, one bit each.
// - Info read at any member returns bits of all enabled members.
// - Members coordinate over two select lines and one read strobe.
module grouped_status_bus_reporter (
   input  wire logic       CLK,
   input  wire logic       SRST,
   input  wire logic       CS_N,
   input  wire logic       RD_N,
   input  wire logic       WR_N,
   input  wire logic [7:0] ADDR,
   input  wire logic [7:0] DATA_IN,
   output logic      [7:0] DATA_OUT,
   output logic      [7:0] DATA_OE,
   input  wire logic       GSEL_A_IN,
   output logic            GSEL_A_OUT,
   output logic            GSEL_A_OE,
   input  wire logic       GSEL_B_IN,
   output logic            GSEL_B_OUT,
   output logic            GSEL_B_OE,
   input  wire logic       GRD_N_IN,
   output logic            GRD_N_OUT,
   output logic            GRD_N_OE,
   input  wire logic       E1_MODE,
   input  wire logic       IRQ_PENDING,
   input  wire logic       SYNC_LOSS,
   input  wire logic       BLUE_ALARM,
   input  wire logic       YELLOW_ALARM,
   input  wire logic       LOOP_UP_DETECT,
   input  wire logic       LOOP_DOWN_DETECT,
   input  wire logic       UNFRAMED_ALL_ONES,
   input  wire logic       REMOTE_ALARM,
   input  wire logic       DIST_MF_ALARM,
   input  wire logic       V5_LINK_DETECT,
   input  wire logic       SIGNALING_CHANGE,
   input  wire logic       ELASTIC_STORE_SLIP
);

   logic [7:0] ctrl_a_q;
   logic [7:0] ctrl_b_q;
   logic [7:0] data_d;
   logic [7:0] oe_d;
   logic [7:0] data_q;
   logic [7:0] oe_q;
   logic       gsel_a_oe_q;
   logic       gsel_b_oe_q;
   logic       grd_oe_q;
   logic       pin_low_q;
   logic       host_rd;
   logic       host_wr;
   logic       ctrl_rd;
   logic       info_rd;
   logic       grp_req;
   logic       resp_on;
   logic [1:0] local_idx;
   logic [1:0] resp_idx;
   logic       resp_bit;
   logic [7:0] ctrl_val;
   logic       group_enable;
   logic [2:0] line_sel;
   logic [2:0] third_sel;
   logic [2:0] fourth_sel;

   // Field views of the control registers
   assign group_enable = ctrl_a_q[group_status_pkg::ENABLE_BIT];
   assign line_sel     = ctrl_a_q[group_status_pkg::LINE_SEL_LSB +: 3];
   assign third_sel    = ctrl_b_q[group_status_pkg::SRC_A_LSB +: 3];
   assign fourth_sel   = ctrl_b_q[group_status_pkg::SRC_B_LSB +: 3];

   // Map a select code to a status source for the current line mode
   function automatic logic pick_source(input logic [2:0] code, input logic e1);
      logic r;
      r = 1'h0;
      unique case (code)
         group_status_pkg::SRC_ALARM0: r = e1 ? UNFRAMED_ALL_ONES : BLUE_ALARM;
         group_status_pkg::SRC_ALARM1: r = e1 ? REMOTE_ALARM : YELLOW_ALARM;
         group_status_pkg::SRC_LOOP0:  r = e1 ? DIST_MF_ALARM : LOOP_UP_DETECT;
         group_status_pkg::SRC_LOOP1:  r = e1 ? V5_LINK_DETECT : LOOP_DOWN_DETECT;
         group_status_pkg::SRC_SIGCH:  r = SIGNALING_CHANGE;
         group_status_pkg::SRC_SLIP:   r = ELASTIC_STORE_SLIP;
         default:                      r = 1'h0;
      endcase
      return r;
   endfunction

   // Host access decode
   assign host_rd   = !CS_N && !RD_N;
   assign host_wr   = !CS_N && !WR_N && RD_N;
   assign ctrl_rd   = host_rd && (ADDR == group_status_pkg::OFS_CTRL_A || ADDR == group_status_pkg::OFS_CTRL_B);
   assign info_rd   = host_rd && ADDR >= group_status_pkg::OFS_INFO_IRQ && ADDR <= group_status_pkg::OFS_INFO_UB;
   assign local_idx = 2'(ADDR - group_status_pkg::OFS_INFO_IRQ);
   assign ctrl_val  = (ADDR == group_status_pkg::OFS_CTRL_A) ? ctrl_a_q : ctrl_b_q;

   // Group cycle started by another member: strobe low, index on select lines
   // Own strobe lingers a cycle after the host read ends, so it is masked here
   assign grp_req  = !GRD_N_IN && !info_rd && !grd_oe_q;
   assign resp_on  = info_rd || grp_req;
   assign resp_idx = info_rd ? local_idx : {GSEL_B_IN, GSEL_A_IN};

   // Status bit that this member reports for the requested info register
   always_comb begin
      resp_bit = 1'h0;
      unique case (resp_idx)
         group_status_pkg::IDX_IRQ: resp_bit = IRQ_PENDING;
         group_status_pkg::IDX_LOS: resp_bit = SYNC_LOSS;
         group_status_pkg::IDX_UA:  resp_bit = pick_source(third_sel, E1_MODE);
         group_status_pkg::IDX_UB:  resp_bit = pick_source(fourth_sel, E1_MODE);
      endcase
   end

   // Per-line drive: control reads use all lines, group reads one line
   for (genvar i = 0; i < group_status_pkg::BUS_LINES; i++) begin : g_line
      assign data_d[i] = ctrl_rd ? ctrl_val[i] : resp_bit;
      assign oe_d[i]   = ctrl_rd || (resp_on && group_enable && line_sel == 3'(i));
   end

   // Control register writes; unused bits are not stored
   always_ff @(posedge CLK) begin
      if (SRST) begin
         ctrl_a_q <= group_status_pkg::CTRL_A_RST;
         ctrl_b_q <= group_status_pkg::CTRL_B_RST;
      end else if (host_wr && ADDR == group_status_pkg::OFS_CTRL_A) begin
         ctrl_a_q <= DATA_IN & group_status_pkg::CTRL_A_MASK;
      end else if (host_wr && ADDR == group_status_pkg::OFS_CTRL_B) begin
         ctrl_b_q <= DATA_IN & group_status_pkg::CTRL_B_MASK;
      end
   end

   // Registered data bus drive
   always_ff @(posedge CLK) begin
      if (SRST) begin
         data_q <= 8'h00;
         oe_q   <= 8'h00;
      end else begin
         data_q <= data_d;
         oe_q   <= oe_d;
      end
   end

   // Group pins are open drain: during an info read the strobe and the select lines for zero index bits pull low
   always_ff @(posedge CLK) begin
      if (SRST) begin
         gsel_a_oe_q <= 1'h0;
         gsel_b_oe_q <= 1'h0;
         grd_oe_q    <= 1'h0;
         pin_low_q   <= 1'h0;
      end else begin
         gsel_a_oe_q <= info_rd && !local_idx[0];
         gsel_b_oe_q <= info_rd && !local_idx[1];
         grd_oe_q    <= info_rd;
         pin_low_q   <= 1'h0;
      end
   end

   // Pin outputs come straight from the flip-flops above
   assign DATA_OUT   = data_q;
   assign DATA_OE    = oe_q;
   assign GSEL_A_OUT = pin_low_q;
   assign GSEL_A_OE  = gsel_a_oe_q;
   assign GSEL_B_OUT = pin_low_q;
   assign GSEL_B_OE  = gsel_b_oe_q;
   assign GRD_N_OUT  = pin_low_q;
   assign GRD_N_OE   = grd_oe_q;

   // Checks
   reset_value_a: assert property (@(posedge CLK) SRST |=> ctrl_a_q == 8'h00 && ctrl_b_q == 8'h00)
      else $error("control registers not cleared by reset");
   disabled_quiet_a: assert property (@(posedge CLK) disable iff (SRST)
      (!group_enable && !ctrl_rd) |=> DATA_OE == 8'h00)
      else $error("disabled member drives the bus");
   one_line_a: assert property (@(posedge CLK) disable iff (SRST)
      (resp_on && !ctrl_rd && group_enable) |=> DATA_OE == (8'h01 << $past(line_sel)))
      else $error("group read drives wrong line");
   irq_report_a: assert property (@(posedge CLK) disable iff (SRST)
      (info_rd && ADDR == group_status_pkg::OFS_INFO_IRQ) |=> DATA_OUT[$past(line_sel)] == $past(IRQ_PENDING))
      else $error("interrupt status not reported");
   sync_report_a: assert property (@(posedge CLK) disable iff (SRST)
      (info_rd && ADDR == group_status_pkg::OFS_INFO_LOS) |=> DATA_OUT[$past(line_sel)] == $past(SYNC_LOSS))
      else $error("sync loss status not reported");
   third_e1_a: assert property (@(posedge CLK) disable iff (SRST)
      (info_rd && ADDR == group_status_pkg::OFS_INFO_UA && E1_MODE && third_sel == 3'h1)
      |=> DATA_OUT[$past(line_sel)] == $past(REMOTE_ALARM))
      else $error("third register E1 source wrong");
   fourth_t1_a: assert property (@(posedge CLK) disable iff (SRST)
      (info_rd && ADDR == group_status_pkg::OFS_INFO_UB && !E1_MODE && fourth_sel == 3'h0)
      |=> DATA_OUT[$past(line_sel)] == $past(BLUE_ALARM))
      else $error("fourth register T1 source wrong");
   strobe_out_a: assert property (@(posedge CLK) disable iff (SRST)
      info_rd |=> GRD_N_OE && !GRD_N_OUT && GSEL_A_OE == !$past(local_idx[0]))
      else $error("group strobe not issued");
   member_answer_a: assert property (@(posedge CLK) disable iff (SRST)
      (grp_req && group_enable && {GSEL_B_IN, GSEL_A_IN} == group_status_pkg::IDX_LOS)
      |=> DATA_OE[$past(line_sel)] && DATA_OUT[$past(line_sel)] == $past(SYNC_LOSS))
      else $error("member ignored group strobe");
   third_t1_a: assert property (@(posedge CLK) disable iff (SRST)
      (info_rd && ADDR == group_status_pkg::OFS_INFO_UA && !E1_MODE && third_sel == 3'h4)
      |=> DATA_OUT[$past(line_sel)] == $past(SIGNALING_CHANGE))
      else $error("third register T1 source wrong");
   fourth_e1_a: assert property (@(posedge CLK) disable iff (SRST)
      (info_rd && ADDR == group_status_pkg::OFS_INFO_UB && E1_MODE && fourth_sel == 3'h3)
      |=> DATA_OUT[$past(line_sel)] == $past(V5_LINK_DETECT))
      else $error("fourth register E1 source wrong");
   blank_code_a: assert property (@(posedge CLK) disable iff (SRST)
      (info_rd && ADDR == group_status_pkg::OFS_INFO_UA && third_sel[2:1] == 2'h3)
      |=> DATA_OUT[$past(line_sel)] == 1'h0)
      else $error("unused source code reports status");
   own_strobe_a: assert property (@(posedge CLK) disable iff (SRST)
      (grd_oe_q && !info_rd && !ctrl_rd)
      |=> DATA_OE == 8'h00)
      else $error("member answered its own strobe");

endmodule // grouped_status_bus_reporter

// ===== rtl/group_status_pkg.sv
package group_status_pkg;
   // Register offsets on the parallel host port
   localparam logic [7:0] OFS_CTRL_A   = 8'hB0;
   localparam logic [7:0] OFS_CTRL_B   = 8'hB1;
   localparam logic [7:0] OFS_INFO_IRQ = 8'hB2;
   localparam logic [7:0] OFS_INFO_LOS = 8'hB3;
   localparam logic [7:0] OFS_INFO_UA  = 8'hB4;
   localparam logic [7:0] OFS_INFO_UB  = 8'hB5;
   // Reset values
   localparam logic [7:0] CTRL_A_RST   = 8'h00;
   localparam logic [7:0] CTRL_B_RST   = 8'h00;
   // Field positions
   localparam int ENABLE_BIT   = 0;
   localparam int LINE_SEL_LSB = 1;
   localparam int SRC_A_LSB    = 0;
   localparam int SRC_B_LSB    = 4;
   // Writable bits; unused bits read as zero
   localparam logic [7:0] CTRL_A_MASK  = 8'h0F;
   localparam logic [7:0] CTRL_B_MASK  = 8'h77;
   // Information register index carried on the group select lines
   localparam logic [1:0] IDX_IRQ = 2'h0;
   localparam logic [1:0] IDX_LOS = 2'h1;
   localparam logic [1:0] IDX_UA  = 2'h2;
   localparam logic [1:0] IDX_UB  = 2'h3;
   // Status source select codes
   localparam logic [2:0] SRC_ALARM0 = 3'h0;
   localparam logic [2:0] SRC_ALARM1 = 3'h1;
   localparam logic [2:0] SRC_LOOP0  = 3'h2;
   localparam logic [2:0] SRC_LOOP1  = 3'h3;
   localparam logic [2:0] SRC_SIGCH  = 3'h4;
   localparam logic [2:0] SRC_SLIP   = 3'h5;
   localparam int BUS_LINES = 8;
endpackage

// ===== dv/group_peer.sv
`timescale 1ns/1ps
// Neighbour group member that answers the shared group strobe
module group_peer (
   input  wire logic       clk,
   input  wire logic       grd_n,
   input  wire logic [1:0] idx,
   input  wire logic [3:0] flags,
   output logic            oe,
   output logic            val
);
   // Drive the own line one cycle after the strobe is seen low
   always_ff @(posedge clk) begin
      oe  <= !grd_n;
      val <= flags[idx];
   end
endmodule // group_peer

// ===== dv/tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_count++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module tb_top;
   localparam int PEER_LINE = 6;
   logic       clk = 0, srst = 1, cs_n = 1, rd_n = 1, wr_n = 1, e1 = 0, irq = 0, los = 0;
   logic [7:0] addr = 8'h00, wdata = 8'h00, bus, rdat, roe, d_out, d_oe, junk = 8'h5A;
   logic [9:0] st = 10'h000;
   logic [3:0] pflags = 4'h5;
   logic       tb_grd = 0, tb_sb = 0, p_oe, p_val, sa_oe, sb_oe, grd_oe, sa_o, sb_o, grd_o;
   int         err_count = 0, n_compared = 0;
   // Clock, and a pattern for lines nobody drives
   always #25 clk = ~clk;
   always @(posedge clk) junk <= ~junk;
   // Open-drain group pins with pull-ups, then the shared data bus
   wire grd_w = (grd_oe ? grd_o : 1'h1) & !tb_grd;
   wire sa_w = sa_oe ? sa_o : 1'h1;
   wire sb_w = (sb_oe ? sb_o : 1'h1) & !tb_sb;
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         bus[i] = d_oe[i] ? d_out[i] : (i == PEER_LINE && p_oe) ? p_val : junk[i];
      end
   end
   grouped_status_bus_reporter grouped_status_bus_reporter_i (.CLK(clk), .SRST(srst), .CS_N(cs_n), .RD_N(rd_n),
      .WR_N(wr_n), .ADDR(addr), .DATA_IN(wdata), .DATA_OUT(d_out), .DATA_OE(d_oe), .GSEL_A_IN(sa_w),
      .GSEL_A_OUT(sa_o), .GSEL_A_OE(sa_oe), .GSEL_B_IN(sb_w), .GSEL_B_OUT(sb_o), .GSEL_B_OE(sb_oe),
      .GRD_N_IN(grd_w), .GRD_N_OUT(grd_o), .GRD_N_OE(grd_oe), .E1_MODE(e1), .IRQ_PENDING(irq),
      .SYNC_LOSS(los), .BLUE_ALARM(st[0]),
      .YELLOW_ALARM(st[1]), .LOOP_UP_DETECT(st[2]), .LOOP_DOWN_DETECT(st[3]), .UNFRAMED_ALL_ONES(st[4]),
      .REMOTE_ALARM(st[5]), .DIST_MF_ALARM(st[6]), .V5_LINK_DETECT(st[7]), .SIGNALING_CHANGE(st[8]),
      .ELASTIC_STORE_SLIP(st[9]));
   group_peer group_peer_i (.clk(clk), .grd_n(grd_w), .idx({sb_w, sa_w}), .flags(pflags), .oe(p_oe), .val(p_val));
   // Host write: one cycle with the strobes low
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      #2;
      cs_n = 0;
      wr_n = 0;
      addr = a;
      wdata = d;
      @(posedge clk);
      #2;
      cs_n = 1;
      wr_n = 1;
   endtask
   // Host read: held three cycles, sampled in the third
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      #2;
      cs_n = 0;
      rd_n = 0;
      addr = a;
      repeat (2) @(posedge clk);
      #10;
      rdat = bus;
      roe = d_oe;
      @(posedge clk);
      #2;
      cs_n = 1;
      rd_n = 1;
   endtask
   // Status input index for a source code in a mode
   function automatic int src(input int m, input int c);
      return (c < 4) ? c + 4 * m : c + 4;
   endfunction
   task automatic results();
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // Watchdog against a hung run
   initial begin
      #1000000;
      err_count++;
      results();
   end
   initial begin
      repeat (4) @(posedge clk);
      #2;
      srst = 0;
      rd(8'hB0);
      `CHK("ctrl_a reset", 8'h00, rdat)
      rd(8'hB1);
      `CHK("ctrl_b reset", 8'h00, rdat)
      wr(8'hB0, 8'h0F);
      rd(8'hB0);
      `CHK("ctrl_a bits", 8'h0F, rdat)
      wr(8'hB1, 8'h77);
      rd(8'hB1);
      `CHK("ctrl_b bits", 8'h77, rdat)
      rd(8'hB6);
      `CHK("unmapped oe", 8'h00, roe)
      wr(8'hB0, 8'h0A);
      irq = 1;
      rd(8'hB2);
      `CHK("disabled oe", 8'h00, roe)
      $display("test registers done");
      // Walk every line select except the neighbour's line 6, while the neighbour reports on it
      for (int n = 0; n < 8; n++) begin
         if (n == PEER_LINE) continue;
         wr(8'hB0, 8'(n * 2 + 1));
         irq = n[0];
         los = !n[0];
         pflags = 4'(n);
         rd(8'hB2);
         `CHK("line oe", 8'(1 << n), roe)
         `CHK("irq bit", n[0], rdat[n])
         `CHK("peer irq", pflags[0], rdat[PEER_LINE])
         rd(8'hB3);
         `CHK("los bit", !n[0], rdat[n])
         `CHK("peer los", pflags[1], rdat[PEER_LINE])
      end
      $display("test line select done");
      // Every source code in both modes, for both user registers
      wr(8'hB0, 8'h01);
      for (int m = 0; m < 2; m++) begin
         e1 = m[0];
         for (int c = 0; c < 8; c++) begin
            st = (c < 6) ? 10'(1 << src(m, c)) : 10'h3FF;
            wr(8'hB1, 8'h60 | 8'(c));
            rd(8'hB4);
            `CHK("source a", c < 6, rdat[0])
            wr(8'hB1, 8'(c << 4) | 8'h06);
            rd(8'hB5);
            `CHK("source b", c < 6, rdat[0])
         end
      end
      $display("test sources done");
      // Another member strobes the group for the sync loss index
      @(posedge clk);
      #2;
      los = 1;
      tb_sb = 1;
      tb_grd = 1;
      repeat (2) @(posedge clk);
      #10;
      `CHK("member oe", 8'h01, d_oe)
      `CHK("member bit", 1'h1, d_out[0])
      @(posedge clk);
      #2;
      tb_grd = 0;
      tb_sb = 0;
      repeat (3) @(posedge clk);
      #10;
      `CHK("member off", 8'h00, d_oe)
      $display("test group member done");
      // Reset in mid-run clears both control registers again
      @(posedge clk);
      #2;
      srst = 1;
      @(posedge clk);
      #2;
      srst = 0;
      rd(8'hB0);
      `CHK("ctrl_a after reset", 8'h00, rdat)
      rd(8'hB1);
      `CHK("ctrl_b after reset", 8'h00, rdat)
      $display("test mid reset done");
      results();
   end
endmodule // tb_top
